// >>> pan_defines.vh
// register indices, field positions, reset values and codes for the auto-negotiation and indirect-access bank
`ifndef PAN_DEFINES_VH
`define PAN_DEFINES_VH

// register indices on the management port
`define PAN_IDX_EXPANSION 5'h06
`define PAN_IDX_NP_TX 5'h07
`define PAN_IDX_NP_RX 5'h08
`define PAN_IDX_MMD_CTRL 5'h0d
`define PAN_IDX_MMD_ADDR_DATA 5'h0e

// expansion register bit positions
`define PAN_EXP_NP_LOC_ABLE 6
`define PAN_EXP_NP_LOC 5
`define PAN_EXP_PD_FAULT 4
`define PAN_EXP_LP_NP_ABLE 3
`define PAN_EXP_NP_ABLE 2
`define PAN_EXP_PAGE_RCVD 1
`define PAN_EXP_LP_AN_ABLE 0

// next-page register fields
`define PAN_NP_NEXT 15
`define PAN_NP_ACK 14
`define PAN_NP_MSG 13
`define PAN_NP_ACK2 12
`define PAN_NP_TOGGLE 11
`define PAN_NP_CODE_MSB 10
`define PAN_NP_CODE_W 11
`define PAN_NP_TX_CODE_RST 11'h001
`define PAN_NP_TX_MSG_RST 1'b1
`define PAN_NP_RX_RST 16'h0000

// indirect-access control fields
`define PAN_MMD_FUNC_MSB 15
`define PAN_MMD_FUNC_LSB 14
`define PAN_MMD_DEV_MSB 4
`define PAN_MMD_DEV_W 5
`define PAN_MMD_FUNC_ADDR 2'h0
`define PAN_MMD_FUNC_DATA 2'h1
`define PAN_MMD_DEV_PCS 5'h03
`define PAN_MMD_DEV_AN 5'h07
`define PAN_MMD_ADDR_RST 16'h0000

`endif

// >>> pan_latch_high.v
// latching-high status bits, cleared by a read of their register
`timescale 1ns/1ns
module pan_latch_high #(
  parameter WIDTH = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [WIDTH-1:0] event_i,
  input wire clear_i,
  output reg [WIDTH-1:0] status_o
);

  // a new event in the clearing cycle wins, so nothing is lost
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= {WIDTH{1'b0}};
    end else begin
      status_o <= event_i | (status_o & {WIDTH{~clear_i}}); // see RULE18
    end
  end

endmodule

// >>> pan_mmd_window.v
// indirect window into the mdio manageable device register space
`timescale 1ns/1ns
`include "pan_defines.vh"
module pan_mmd_window (
  input wire clk_i,
  input wire rst_n_i,
  input wire ctrl_wr_i,
  input wire ad_wr_i,
  input wire ad_rd_i,
  input wire [15:0] wdata_i,
  input wire [15:0] mmd_rdata_i,
  output wire [15:0] ctrl_o,
  output reg [15:0] ad_rdata_o,
  output reg [`PAN_MMD_DEV_W-1:0] mmd_device_select_o,
  output reg [15:0] mmd_addr_o,
  output reg [15:0] mmd_wdata_o,
  output reg mmd_wr_o,
  output wire mmd_rd_o
);

  reg [1:0] func_reg;
  wire func_is_addr;
  wire func_is_data;

  assign func_is_addr = (func_reg == `PAN_MMD_FUNC_ADDR); // see RULE13
  assign func_is_data = (func_reg == `PAN_MMD_FUNC_DATA);
  // reserved bits 13:5 read as zero
  assign ctrl_o = {func_reg, 9'h000, mmd_device_select_o}; // see RULE14
  // read strobe goes straight out so the device can answer in the same cycle
  assign mmd_rd_o = ad_rd_i & func_is_data; // see RULE16

  // control register: function and device selector
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      func_reg <= `PAN_MMD_FUNC_ADDR;
      mmd_device_select_o <= {`PAN_MMD_DEV_W{1'b0}};
    end else if (ctrl_wr_i) begin
      func_reg <= wdata_i[`PAN_MMD_FUNC_MSB:`PAN_MMD_FUNC_LSB]; // see RULE13
      mmd_device_select_o <= wdata_i[`PAN_MMD_DEV_MSB:0]; // see RULE14
    end
  end

  // address latch; never incremented, only function 01 exists for data
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mmd_addr_o <= `PAN_MMD_ADDR_RST;
    end else if (ad_wr_i && func_is_addr) begin
      mmd_addr_o <= wdata_i; // see RULE15
    end
  end

  // data writes pass out one cycle later with their data held in flops
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mmd_wr_o <= 1'b0;
      mmd_wdata_o <= 16'h0000;
    end else begin
      mmd_wr_o <= ad_wr_i & func_is_data; // see RULE16
      if (ad_wr_i && func_is_data) begin
        mmd_wdata_o <= wdata_i;
      end
    end
  end

  // read view of the address/data register; reserved functions read zero
  always @* begin
    if (func_is_addr) begin
      ad_rdata_o = mmd_addr_o; // see RULE15
    end else if (func_is_data) begin
      ad_rdata_o = mmd_rdata_i; // see RULE16
    end else begin
      ad_rdata_o = 16'h0000;
    end
  end

endmodule

// >>> pan_regs.v
// management register bank: expansion status, next-page exchange and mmd indirect access
`timescale 1ns/1ns
`include "pan_defines.vh"
// Operation
// RULE1 - expansion bit 6 reads constant one
// RULE2 - bit 5 one; next pages in register 8
// RULE3 - bit 4 latches parallel detection fault
// RULE4 - bit 3 follows partner next-page ability
// RULE5 - bit 2 reads one: local next-page able
// RULE6 - bit 1 latches new page received
// RULE7 - bit 0 follows partner autoneg ability
// RULE8 - transmit page: writable next, code resets one
// RULE9 - toggle bits read-only, reset zero
// RULE10 - bit 12 acknowledge-2, writable in transmit
// RULE11 - bit 13 message page, transmit resets one
// RULE12 - receive page fully read-only, resets zero
// RULE13 - function field: 00 address, 01 data
// RULE14 - 5-bit device selector, reserved middle bits
// RULE15 - function 00: register holds mmd address
// RULE16 - function 01: data at latched address, no increment
// RULE17 - controller sets address before data access
// RULE18 - latched bits hold until register read
module pan_regs (
  input wire clk_i,
  input wire rst_n_i,
  // management register port, decoded from the serial management frame
  input wire [4:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // auto-negotiation engine status
  input wire pd_fault_i,
  input wire lp_np_able_i,
  input wire lp_an_able_i,
  input wire page_rcvd_i,
  input wire [15:0] lp_page_i,
  input wire np_tx_taken_i,
  output reg [15:0] np_tx_word_o,
  output reg np_tx_loaded_o,
  // mmd register space
  input wire [15:0] mmd_rdata_i,
  output wire [`PAN_MMD_DEV_W-1:0] mmd_device_select_o,
  output wire [15:0] mmd_addr_o,
  output wire [15:0] mmd_wdata_o,
  output wire mmd_wr_o,
  output wire mmd_rd_o
);

  // decoded strobes
  wire sel_exp;
  wire sel_np_tx;
  wire sel_np_rx;
  wire sel_ctrl;
  wire sel_ad;
  wire exp_rd;
  wire np_tx_wr;
  wire ctrl_wr;
  wire ad_wr;
  wire ad_rd;

  // expansion state
  wire [1:0] lh_event;
  wire [1:0] lh_status;
  reg lp_np_able_reg;
  reg lp_an_able_reg;
  wire [15:0] exp_word;

  // transmit next page fields
  reg np_tx_next_reg;
  reg np_tx_msg_reg;
  reg np_tx_ack2_reg;
  reg np_tx_toggle_reg;
  reg [`PAN_NP_CODE_W-1:0] np_tx_code_reg;
  wire [15:0] np_tx_word;

  // receive next page copy
  reg [15:0] np_rx_reg;

  // indirect-access views
  wire [15:0] ctrl_word;
  wire [15:0] ad_word;
  reg [15:0] rdata_next;

  // address decode of the register port
  assign sel_exp = (reg_addr_i == `PAN_IDX_EXPANSION);
  assign sel_np_tx = (reg_addr_i == `PAN_IDX_NP_TX);
  assign sel_np_rx = (reg_addr_i == `PAN_IDX_NP_RX);
  assign sel_ctrl = (reg_addr_i == `PAN_IDX_MMD_CTRL);
  assign sel_ad = (reg_addr_i == `PAN_IDX_MMD_ADDR_DATA);
  assign exp_rd = reg_rd_i & sel_exp;
  assign np_tx_wr = reg_wr_i & sel_np_tx;
  assign ctrl_wr = reg_wr_i & sel_ctrl;
  assign ad_wr = reg_wr_i & sel_ad;
  assign ad_rd = reg_rd_i & sel_ad;

  // the two latching bits share one clear: any read of the expansion register
  assign lh_event = {pd_fault_i, page_rcvd_i}; // see RULE3 see RULE6

  pan_latch_high #(
    .WIDTH(2)
  ) u_lh (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .event_i(lh_event),
    .clear_i(exp_rd),
    .status_o(lh_status)
  );

  // partner ability levels, registered so reads see a stable value
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lp_np_able_reg <= 1'b0;
      lp_an_able_reg <= 1'b0;
    end else begin
      lp_np_able_reg <= lp_np_able_i; // see RULE4
      lp_an_able_reg <= lp_an_able_i; // see RULE7
    end
  end

  // expansion word; bits 15:7 reserved and read zero
  assign exp_word = {9'h000,
                     1'b1, // see RULE1
                     1'b1, // see RULE2
                     lh_status[1], // see RULE3
                     lp_np_able_reg, // see RULE4
                     1'b1, // see RULE5
                     lh_status[0], // see RULE6
                     lp_an_able_reg}; // see RULE7

  // transmit next page: writable fields, reserved bit 14 ignored on write
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      np_tx_next_reg <= 1'b0;
      np_tx_msg_reg <= `PAN_NP_TX_MSG_RST; // see RULE11
      np_tx_ack2_reg <= 1'b0;
      np_tx_code_reg <= `PAN_NP_TX_CODE_RST; // see RULE8
    end else if (np_tx_wr) begin
      np_tx_next_reg <= reg_wdata_i[`PAN_NP_NEXT]; // see RULE8
      np_tx_msg_reg <= reg_wdata_i[`PAN_NP_MSG]; // see RULE11
      np_tx_ack2_reg <= reg_wdata_i[`PAN_NP_ACK2]; // see RULE10
      np_tx_code_reg <= reg_wdata_i[`PAN_NP_CODE_MSB:0]; // see RULE8
    end
  end

  // toggle flips each time the engine sends a page; software cannot touch it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      np_tx_toggle_reg <= 1'b0;
    end else if (np_tx_taken_i) begin
      np_tx_toggle_reg <= ~np_tx_toggle_reg; // see RULE9
    end
  end

  assign np_tx_word = {np_tx_next_reg, 1'b0, np_tx_msg_reg, np_tx_ack2_reg,
                       np_tx_toggle_reg, np_tx_code_reg};

  // page offered to the engine, flagged once per software load
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // reset image built from constants only, the field flops reset in the same instant
      np_tx_word_o <= {1'b0, 1'b0, `PAN_NP_TX_MSG_RST, 2'b00, `PAN_NP_TX_CODE_RST};
      np_tx_loaded_o <= 1'b0;
    end else begin
      np_tx_word_o <= np_tx_word;
      np_tx_loaded_o <= np_tx_wr;
    end
  end

  // receive copy captured whole on each received page, writes have no effect
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      np_rx_reg <= `PAN_NP_RX_RST; // see RULE12
    end else if (page_rcvd_i) begin
      np_rx_reg <= lp_page_i; // see RULE2 see RULE12 see RULE9
    end
  end

  // indirect window; relies on the controller setting the address first
  pan_mmd_window u_mmd (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ctrl_wr_i(ctrl_wr),
    .ad_wr_i(ad_wr), // see RULE17
    .ad_rd_i(ad_rd),
    .wdata_i(reg_wdata_i),
    .mmd_rdata_i(mmd_rdata_i),
    .ctrl_o(ctrl_word),
    .ad_rdata_o(ad_word),
    .mmd_device_select_o(mmd_device_select_o),
    .mmd_addr_o(mmd_addr_o),
    .mmd_wdata_o(mmd_wdata_o),
    .mmd_wr_o(mmd_wr_o),
    .mmd_rd_o(mmd_rd_o)
  );

  // read mux; unmapped indices read zero
  always @* begin
    rdata_next = 16'h0000;
    if (sel_exp) begin
      rdata_next = exp_word;
    end else if (sel_np_tx) begin
      rdata_next = np_tx_word;
    end else if (sel_np_rx) begin
      rdata_next = np_rx_reg;
    end else if (sel_ctrl) begin
      rdata_next = ctrl_word;
    end else if (sel_ad) begin
      rdata_next = ad_word;
    end
  end

  // read data held in flops until the next read
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_next;
      end
    end
  end

endmodule

// >>> pan_regs_sva.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module pan_regs_sva (
  input wire clk_i,
  input wire rst_n_i,
  input wire [4:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire pd_fault_i,
  input wire lp_np_able_i,
  input wire lp_an_able_i,
  input wire page_rcvd_i,
  input wire [15:0] lp_page_i,
  input wire np_tx_taken_i,
  input wire [15:0] np_tx_word_o,
  input wire np_tx_loaded_o,
  input wire [15:0] mmd_rdata_i,
  input wire [4:0] mmd_device_select_o,
  input wire [15:0] mmd_addr_o,
  input wire [15:0] mmd_wdata_o,
  input wire mmd_wr_o,
  input wire mmd_rd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] last_page;
  logic pd_seen, pg_seen;
  // events since the last expansion read; an event in the read cycle survives the clear
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) {pd_seen, pg_seen} <= 2'b00;
    else if (reg_rd_i && reg_addr_i == 5'h06) {pd_seen, pg_seen} <= {pd_fault_i, page_rcvd_i};
    else {pd_seen, pg_seen} <= {pd_seen | pd_fault_i, pg_seen | page_rcvd_i};
  // shadow of the partner page, so capture is checked without a design hook
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) last_page <= 16'h0000;
    else if (page_rcvd_i) last_page <= lp_page_i;
  exp_const_a: assert property (reg_rd_i && reg_addr_i == 5'h06 |=> reg_rdata_o[15:5] == 11'h003 && reg_rdata_o[2])
    else $error("expansion constant bits wrong");
  pd_latch_a: assert property (reg_rd_i && reg_addr_i == 5'h06 |=> reg_rdata_o[4] == $past(pd_seen))
    else $error("fault bit not latched");
  page_latch_a: assert property (reg_rd_i && reg_addr_i == 5'h06 |=> reg_rdata_o[1] == $past(pg_seen))
    else $error("page bit not latched");
  lp_status_a: assert property (reg_rd_i && reg_addr_i == 5'h06 |=> reg_rdata_o[3] == $past(lp_np_able_i, 2) && reg_rdata_o[0] == $past(lp_an_able_i, 2))
    else $error("partner status bits wrong");
  rx_page_a: assert property (reg_rd_i && reg_addr_i == 5'h08 |=> reg_rdata_o == $past(last_page))
    else $error("receive page wrong");
  mmd_rd_a: assert property (mmd_rd_o |-> reg_rd_i && reg_addr_i == 5'h0e)
    else $error("stray mmd read");
  mmd_wr_a: assert property (mmd_wr_o |-> $past(reg_wr_i && reg_addr_i == 5'h0e) && mmd_wdata_o == $past(reg_wdata_i) && $stable(mmd_addr_o))
    else $error("mmd write wrong");
  mmd_rdata_a: assert property (mmd_rd_o |=> reg_rvalid_o && reg_rdata_o == $past(mmd_rdata_i))
    else $error("mmd read data wrong");
  dev_sel_a: assert property (reg_wr_i && reg_addr_i == 5'h0d |=> mmd_device_select_o == $past(reg_wdata_i[4:0]))
    else $error("device select wrong");
  tx_load_a: assert property (reg_wr_i && reg_addr_i == 5'h07 |=> np_tx_loaded_o)
    else $error("transmit load pulse missing");
  tx_toggle_a: assert property (np_tx_taken_i |=> ##1 np_tx_word_o[11] != $past(np_tx_word_o[11]))
    else $error("transmit toggle did not flip");
  cover property (mmd_wr_o);
  cover property (mmd_rd_o);
  cover property (page_rcvd_i ##1 reg_rd_i);
endmodule
bind pan_regs pan_regs_sva pan_regs_sva_inst (.*);

// >>> pan_mmd_model.sv
// small mmd register space answering the indirect window
`timescale 1ns/1ns
module pan_mmd_model (
  input wire clk_i,
  input wire [4:0] mmd_device_select_o,
  input wire [15:0] mmd_addr_o,
  input wire [15:0] mmd_wdata_o,
  input wire mmd_wr_o,
  input wire mmd_rd_o,
  output logic [15:0] mmd_rdata_i
);
  logic [15:0] mem [0:31];
  logic [15:0] noise = 16'h5a5a;
  // folded index: only a few addresses are used, aliasing is accepted
  always @(posedge clk_i) begin
    noise <= noise + 16'h1357;
    if (mmd_wr_o) mem[{mmd_device_select_o[2], mmd_addr_o[3:0]}] <= mmd_wdata_o;
  end
  // outside a read the bus shows a moving pattern, never the last value
  always_comb mmd_rdata_i = mmd_rd_o ? mem[{mmd_device_select_o[2], mmd_addr_o[3:0]}] : noise;
endmodule

// >>> pan_tb.sv
// self-checking bench for the management register bank
`timescale 1ns/1ns
module tb;
  logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, pd_fault_i = 0, page_rcvd_i = 0;
  logic lp_np_able_i = 0, lp_an_able_i = 0, np_tx_taken_i = 0, reg_rvalid_o, np_tx_loaded_o, mmd_wr_o, mmd_rd_o;
  logic [4:0] reg_addr_i = 0, mmd_device_select_o;
  logic [15:0] reg_wdata_i = 0, lp_page_i = 0, reg_rdata_o, mmd_rdata_i, np_tx_word_o, mmd_addr_o, mmd_wdata_o;
  logic [15:0] d, a, p, rv;
  logic tog = 0;
  int fail_count = 0, cmp_count = 0;
  localparam logic [4:0] IDX [6] = '{5'h06, 5'h07, 5'h08, 5'h0d, 5'h0e, 5'h03};
  localparam logic [4:0] DEV [2] = '{5'h03, 5'h07};
  always #5 clk_i = ~clk_i;
  pan_regs pan_regs_inst (.*);
  pan_mmd_model pan_mmd_model_inst (.*);
  function automatic logic [15:0] rst_val(input logic [4:0] ad);
    return ad == 5'h06 ? 16'h0064 : ad == 5'h07 ? 16'h2001 : 16'h0000;
  endfunction
  function automatic logic [15:0] exp_tx(input logic [15:0] w, input logic t);
    return {w[15], 1'b0, w[13:12], t, w[10:0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one register access; a read leaves its data in rv
  task automatic acc(input logic w, input logic [4:0] ad, input logic [15:0] wd);
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= ad;
    reg_wdata_i <= wd;
    @(posedge clk_i);
    reg_wr_i <= 0;
    reg_rd_i <= 0;
    #1 rv = reg_rdata_o;
    if (!w) chk("rvalid", {15'h0, reg_rvalid_o}, 16'h0001);
  endtask
  // one-cycle engine event: 0 fault, 1 page, 2 page sent
  task automatic ev(input int k);
    @(posedge clk_i);
    pd_fault_i <= k == 0;
    page_rcvd_i <= k == 1;
    np_tx_taken_i <= k == 2;
    lp_page_i <= p;
    @(posedge clk_i);
    {pd_fault_i, page_rcvd_i, np_tx_taken_i} <= 3'b000;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog well beyond the roughly 125 cycles the sequence needs
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h5ab23b4e));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1;
    foreach (IDX[i]) begin
      acc(0, IDX[i], 0);
      chk("reset", rv, rst_val(IDX[i]));
    end
    ev(0);
    acc(0, 6, 0);
    chk("fault set", rv, 16'h0074);
    acc(0, 6, 0);
    chk("fault clear", rv, 16'h0064);
    p = 16'($urandom);
    ev(1);
    acc(0, 6, 0);
    chk("page set", rv, 16'h0066);
    acc(1, 8, ~p);
    acc(0, 8, 0);
    chk("rx page", rv, p);
    repeat (3) begin
      d = 16'($urandom);
      acc(1, 7, d);
      chk("tx loaded", {15'h0, np_tx_loaded_o}, 16'h0001);
      acc(1, 6, d);
      chk("tx idle", {15'h0, np_tx_loaded_o}, 16'h0000);
      ev(2);
      tog = ~tog;
      acc(0, 7, 0);
      chk("tx page", rv, exp_tx(d, tog));
      chk("tx word", np_tx_word_o, exp_tx(d, tog));
    end
    repeat (4) begin
      @(posedge clk_i);
      {lp_np_able_i, lp_an_able_i} <= 2'($urandom);
      acc(0, 6, 0);
      chk("status", rv, {12'h006, lp_np_able_i, 2'b10, lp_an_able_i});
    end
    acc(1, 13, 16'hffff);
    acc(0, 13, 0);
    chk("control", rv, 16'hc01f);
    acc(0, 14, 0);
    chk("reserved func", rv, 16'h0000);
    foreach (DEV[i]) begin
      a = {12'h0, 4'($urandom)};
      d = 16'($urandom);
      acc(1, 13, {11'h0, DEV[i]});
      acc(1, 14, a);
      acc(0, 14, 0);
      chk("mmd addr", rv, a);
      acc(1, 13, {11'h200, DEV[i]});
      acc(1, 14, d);
      repeat (2) begin
        acc(0, 14, 0);
        chk("mmd data", rv, d);
      end
      acc(1, 13, {11'h0, DEV[i]});
      acc(0, 14, 0);
      chk("addr kept", rv, a);
    end
    // mid-run reset: every register written above must fall back to its default
    @(posedge clk_i);
    rst_n_i <= 0;
    {lp_np_able_i, lp_an_able_i} <= 2'b00;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1;
    foreach (IDX[i]) begin
      acc(0, IDX[i], 0);
      chk("rereset", rv, rst_val(IDX[i]));
    end
    chk("tx word reset", np_tx_word_o, 16'h2001);
    wrap_up;
  end
endmodule
